// >>> core/scp_pkg.sv
// Constants shared by the sync, clock and multi-function pin control block.
package scp_pkg;

   // Reference clock period in nanoseconds (40 MHz).
   localparam int CLK_PERIOD_NS = 25;

   // Width of one colour data bus.
   localparam int DATA_W = 10;

   // Least active time of composite sync that marks a vertical broad pulse, in ns.
   localparam int VSEP_MIN_NS = 10000;
   // The same least time in reference cycles, rounded up.
   localparam int VSEP_CYC = (VSEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of the broad pulse counter.
   localparam int VSEP_W = 10;

   // Cycles after reset release before the address strap is latched.
   localparam int STRAP_CYC = 4;
   // Width of the strap window counter.
   localparam int STRAP_W = 3;

   // Positions in the synchronised pin vector.
   localparam int PIN_HS = 0;
   localparam int PIN_VS = 1;
   localparam int PIN_CS = 2;
   localparam int PIN_COAST = 3;
   localparam int PIN_EXTERNAL_PIXEL_CLOCK_IN = 4;
   localparam int PIN_PD = 5;
   localparam int PIN_STRAP = 6;
   localparam int PIN_N = 7;

   // Polarity setting fields: bit 1 selects automatic, bit 0 is the manual level.
   localparam int POL_AUTO_BIT = 1;
   localparam int POL_LVL_BIT = 0;
   // Coast polarity setting after reset: manual, active high.
   localparam logic [1:0] COAST_POL_RST = 2'h1;

   // Auto polarity detector counter width and its mid-scale start value.
   localparam int AUTO_W = 8;
   localparam logic [AUTO_W-1:0] AUTO_MID = 8'h80;

   // Reset value of the internal pixel clock half-period counter.
   localparam logic [7:0] PLL_CNT_RST = 8'h00;

   // Polarity decode: automatic result or the manual level.
   function automatic logic pol_decode(input logic [1:0] setting, input logic detected);
      pol_decode = setting[POL_AUTO_BIT] ? detected : setting[POL_LVL_BIT];
   endfunction : pol_decode

endpackage : scp_pkg

// >>> core/scp_clk_switch.sv
// Runt-free switch between the internal and external pixel clock levels.
module scp_clk_switch (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic int_clk_i,
   input wire logic ext_clk_i,
   input wire logic sel_ext_i,
   output logic clk_o,
   output logic ext_active_o
);
   import scp_pkg::*;

   logic act_ext; // Source currently feeding the output.
   logic gate; // Output enable; low while the switch is in flight.
   logic cur_lvl; // Level of the source in use.
   logic new_lvl; // Level of the source that was asked for.

   assign cur_lvl = act_ext ? ext_clk_i : int_clk_i;
   assign new_lvl = sel_ext_i ? ext_clk_i : int_clk_i;

   // The old source is cut only while it is low and the new one is let in
   // only while it is low, so no shortened high or low phase can escape.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         act_ext <= 1'b0;
         gate <= 1'b1;
      end else if (gate && (sel_ext_i != act_ext) && !cur_lvl) begin
         gate <= 1'b0;
      end else if (!gate && !new_lvl) begin
         act_ext <= sel_ext_i;
         gate <= 1'b1;
      end
   end

   // The gated level is registered so the output comes from a flip-flop.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         clk_o <= 1'b0;
         ext_active_o <= 1'b0;
      end else begin
         clk_o <= gate & cur_lvl;
         ext_active_o <= gate & act_ext;
      end
   end

   // A selection of the external clock that stays put must take effect in bounded time.
   chk_switch_done: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(sel_ext_i) ##1 sel_ext_i[*8] |-> act_ext)
      else $error("external clock selection did not take effect");

endmodule : scp_clk_switch

// >>> core/scp_pin_ctrl.sv
// Sync regeneration, pixel clock selection, power-down and address strap logic.
//
// Contract
// - Control bit selects external pixel clock.
// - External clock leaves coast function intact.
// - Coast freezes clock frequency and phase.
// - Coast polarity automatic or manually set.
// - Coast polarity setting resets to one.
// - Pin powers down only when manual selected.
// - Horizontal sync regenerated, aligned to pixels.
// - Horizontal output polarity and width programmable.
// - Horizontal output aligned with data clock.
// - Vertical output separated or passed through.
// - One bit inverts vertical output level.
// - Vertical width from source or override.
// - Strap pin gives address low bit.
// - Strap sampled at power-up, pull-up reads one.
// - Strap and vertical output do not interfere.
// - Clock locks to leading horizontal edge only.
// - Vertical input polarity automatic or manual.
module scp_pin_ctrl #(
   parameter int DATA_W = scp_pkg::DATA_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic hsync_pin_i,
   input wire logic vsync_pin_i,
   input wire logic csync_pin_i,
   input wire logic coast_pin_i,
   input wire logic external_pixel_clock_in_i,
   input wire logic power_down_pin_i,
   input wire logic vs_addr_pin_i,
   input wire logic [DATA_W-1:0] red_i,
   input wire logic [DATA_W-1:0] green_i,
   input wire logic [DATA_W-1:0] blue_i,
   input wire logic ext_clk_sel_i,
   input wire logic [1:0] hs_pol_setting_i,
   input wire logic [1:0] vs_pol_setting_i,
   input wire logic [1:0] coast_pol_setting_i,
   input wire logic coast_pol_load_i,
   input wire logic [7:0] pll_half_period_i,
   input wire logic [7:0] hs_width_i,
   input wire logic hs_out_pol_i,
   input wire logic vs_mode_i,
   input wire logic vs_invert_i,
   input wire logic vs_dur_ovr_i,
   input wire logic [7:0] vs_width_i,
   input wire logic pd_manual_sel_i,
   input wire logic pd_pin_pol_i,
   input wire logic pd_reg_i,
   output logic data_clock_out_o,
   output logic [DATA_W-1:0] red_o,
   output logic [DATA_W-1:0] green_o,
   output logic [DATA_W-1:0] blue_o,
   output logic regenerated_hsync_out_o,
   output logic vertical_sync_out_o,
   output logic vertical_sync_out_oe_o,
   output logic bus_address_select_lsb_o,
   output logic powered_down_o,
   output logic ext_clk_active_o,
   output logic coast_active_o
);
   import scp_pkg::*;

   logic [PIN_N-1:0] pin_raw; // All pins that arrive from outside.
   logic [PIN_N-1:0] pin_s1; // First synchroniser stage, read only by the second.
   logic [PIN_N-1:0] pin_s2; // Synchronised pin levels.
   logic [PIN_N-1:0] pin_q; // Previous synchronised levels, for edges.
   logic [2:0] auto_pol; // Detected polarity of hsync, vsync and coast.
   logic hs_pol, vs_pol, coast_pol; // Effective active levels.
   logic [1:0] coast_pol_setting; // Held coast polarity setting.
   logic hs_lvl, hs_lvl_q, hs_lead; // Active hsync and its leading edge.
   logic vs_in_act; // Vertical sync input at its active level.
   logic [7:0] pll_cnt; // Internal pixel clock half-period counter.
   logic int_clk; // Internal pixel clock level.
   logic sw_clk; // Level out of the clock switch.
   logic sw_clk_q; // Previous switch level, for the falling edge.
   logic pix_tick; // One cycle per pixel, at the data clock falling edge.
   logic hs_pend; // Leading edge seen, waiting for the next pixel.
   logic hs_act; // Regenerated horizontal pulse, active high.
   logic [7:0] hs_cnt; // Pixels left in the regenerated pulse.
   logic [VSEP_W-1:0] csep_cnt; // Time composite sync has been active.
   logic sep_vs; // Vertical sync separated from composite sync.
   logic vs_src, vs_src_q; // Selected vertical source and its last value.
   logic vs_act; // Vertical pulse before output polarity.
   logic [7:0] vs_lines; // Lines counted in an override pulse.
   logic [STRAP_W-1:0] strap_cnt; // Cycles since reset release.
   logic strap_done; // Address strap has been captured.

   assign pin_raw = {vs_addr_pin_i, power_down_pin_i, external_pixel_clock_in_i,
                     coast_pin_i, csync_pin_i, vsync_pin_i, hsync_pin_i};

   // Every pin passes two flip-flops; the third stage only serves edge detection.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_q <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_q <= pin_s2;
      end
   end

   // Automatic polarity: the level held longer is the idle one, so the
   // active level is the opposite of the counter's upper half.
   for (genvar g = 0; g < 3; g++) begin : g_auto
      localparam int IDX = (g == 0) ? PIN_HS : (g == 1) ? PIN_VS : PIN_COAST;
      logic [AUTO_W-1:0] cnt;
      always_ff @(posedge ref_clk_i) begin
         if (!rst_n_i) begin
            cnt <= AUTO_MID;
         end else if (pin_s2[IDX] && cnt != '1) begin
            cnt <= cnt + 1'b1;
         end else if (!pin_s2[IDX] && cnt != '0) begin
            cnt <= cnt - 1'b1;
         end
      end
      assign auto_pol[g] = ~cnt[AUTO_W-1];
   end

   // Coast polarity setting is a held value that comes up as one.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         coast_pol_setting <= COAST_POL_RST;
      end else if (coast_pol_load_i) begin
         coast_pol_setting <= coast_pol_setting_i;
      end
   end

   assign hs_pol = pol_decode(hs_pol_setting_i, auto_pol[0]);
   assign vs_pol = pol_decode(vs_pol_setting_i, auto_pol[1]);
   assign coast_pol = pol_decode(coast_pol_setting, auto_pol[2]);
   assign hs_lvl = pin_s2[PIN_HS] ~^ hs_pol;
   assign hs_lvl_q = pin_q[PIN_HS] ~^ hs_pol;
   // Polarity 0 makes this the falling edge, polarity 1 the rising edge.
   assign hs_lead = hs_lvl & ~hs_lvl_q;
   assign vs_in_act = pin_s2[PIN_VS] ~^ vs_pol;
   // Coast is decoded from the pin whatever clock source is chosen.
   assign coast_active_o = pin_s2[PIN_COAST] ~^ coast_pol;

   // Internal pixel clock: a free divider whose phase is pulled to each
   // leading edge. Coast simply skips the pull, so the divider keeps the
   // rate and phase it had; no frequency tracking is modelled here.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pll_cnt <= PLL_CNT_RST;
         int_clk <= 1'b0;
      end else if (hs_lead && !coast_active_o) begin
         pll_cnt <= PLL_CNT_RST;
         int_clk <= 1'b1;
      end else if (pll_cnt + 8'h01 >= pll_half_period_i) begin
         pll_cnt <= PLL_CNT_RST;
         int_clk <= ~int_clk;
      end else begin
         pll_cnt <= pll_cnt + 8'h01;
      end
   end

   scp_clk_switch u_switch (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .int_clk_i(int_clk),
      .ext_clk_i(pin_s2[PIN_EXTERNAL_PIXEL_CLOCK_IN]),
      .sel_ext_i(ext_clk_sel_i),
      .clk_o(sw_clk),
      .ext_active_o(ext_clk_active_o)
   );

   // Power-down follows the pin only under manual selection.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         powered_down_o <= 1'b0;
      end else if (pd_manual_sel_i) begin
         powered_down_o <= pin_s2[PIN_PD] ~^ pd_pin_pol_i;
      end else begin
         powered_down_o <= pd_reg_i;
      end
   end

   // Data clock out; held low while powered down.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sw_clk_q <= 1'b0;
         data_clock_out_o <= 1'b0;
      end else begin
         sw_clk_q <= sw_clk;
         data_clock_out_o <= sw_clk & ~powered_down_o;
      end
   end

   // Data and hsync move on the falling edge so they are settled at the rise.
   assign pix_tick = ~sw_clk & sw_clk_q & ~powered_down_o;

   // A leading edge waits for the next pixel; a new edge beats the clear.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         hs_pend <= 1'b0;
      end else if (hs_lead) begin
         hs_pend <= 1'b1;
      end else if (pix_tick) begin
         hs_pend <= 1'b0;
      end
   end

   // Regenerated pulse counted in pixels; a width of zero acts as one.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         hs_act <= 1'b0;
         hs_cnt <= 8'h00;
      end else if (pix_tick && hs_pend) begin
         hs_act <= 1'b1;
         hs_cnt <= (hs_width_i == 8'h00) ? 8'h01 : hs_width_i;
      end else if (pix_tick && hs_cnt > 8'h01) begin
         hs_cnt <= hs_cnt - 8'h01;
      end else if (pix_tick) begin
         hs_act <= 1'b0;
         hs_cnt <= 8'h00;
      end
   end

   // Data and hsync outputs update together on each pixel tick; power-down clears the data but holds hsync.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         red_o <= '0;
         green_o <= '0;
         blue_o <= '0;
         regenerated_hsync_out_o <= 1'b0;
      end else if (powered_down_o) begin
         red_o <= '0;
         green_o <= '0;
         blue_o <= '0;
      end else if (pix_tick) begin
         red_o <= red_i;
         green_o <= green_i;
         blue_o <= blue_i;
         regenerated_hsync_out_o <= hs_act ~^ hs_out_pol_i;
      end
   end

   // Composite separation: sync active longer than a line pulse is vertical.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         csep_cnt <= '0;
         sep_vs <= 1'b0;
      end else if (!(pin_s2[PIN_CS] ~^ hs_pol)) begin
         csep_cnt <= '0;
         sep_vs <= 1'b0;
      end else if (csep_cnt >= VSEP_W'(VSEP_CYC - 1)) begin
         sep_vs <= 1'b1;
      end else begin
         csep_cnt <= csep_cnt + 1'b1;
      end
   end

   assign vs_src = vs_mode_i ? vs_in_act : sep_vs;

   // Vertical pulse: source timing, or a width in lines when overridden.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         vs_src_q <= 1'b0;
         vs_act <= 1'b0;
         vs_lines <= 8'h00;
      end else begin
         vs_src_q <= vs_src;
         if (!vs_dur_ovr_i) begin
            vs_act <= vs_src;
            vs_lines <= 8'h00;
         end else if (vs_src && !vs_src_q) begin
            vs_act <= 1'b1;
            vs_lines <= 8'h00;
         end else if (vs_act && hs_lead) begin
            vs_lines <= vs_lines + 8'h01;
            if (vs_lines + 8'h01 >= vs_width_i) begin
               vs_act <= 1'b0;
            end
         end
      end
   end

   // Strap window: the pin is not driven until its level has been taken.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         strap_cnt <= '0;
         strap_done <= 1'b0;
         bus_address_select_lsb_o <= 1'b0;
      end else if (!strap_done && strap_cnt == STRAP_W'(STRAP_CYC - 1)) begin
         strap_done <= 1'b1;
         bus_address_select_lsb_o <= pin_s2[PIN_STRAP];
      end else if (!strap_done) begin
         strap_cnt <= strap_cnt + 1'b1;
      end
   end

   // Vertical output pin; the driver only turns on after the strap is held.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         vertical_sync_out_o <= 1'b0;
         vertical_sync_out_oe_o <= 1'b0;
      end else begin
         vertical_sync_out_o <= vs_act ^ vs_invert_i;
         vertical_sync_out_oe_o <= strap_done;
      end
   end

   // A leading edge while not coasting resets the divider phase.
   sequence s_lock_edge;
      hs_lead && !coast_active_o;
   endsequence

   chk_hs_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_lock_edge |=> (pll_cnt == PLL_CNT_RST) && int_clk)
      else $error("clock did not lock to the leading hsync edge");

   chk_coast_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      coast_active_o && hs_lead && (pll_cnt + 8'h01 < pll_half_period_i)
      |=> pll_cnt == $past(pll_cnt) + 8'h01)
      else $error("coast did not hold the clock phase");

   chk_coast_pol_rst: assert property (@(posedge ref_clk_i)
      $rose(rst_n_i) |-> coast_pol_setting == COAST_POL_RST)
      else $error("coast polarity not one after reset");

   chk_pd_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !pd_manual_sel_i && !pd_reg_i |=> !powered_down_o)
      else $error("power-down entered without manual selection");

   // Start of a pulse followed by its programmed width in pixels.
   sequence s_hs_start;
      pix_tick && hs_pend;
   endsequence

   chk_hs_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_hs_start |=> hs_act && hs_cnt != 8'h00)
      else $error("regenerated hsync pulse did not start");

   chk_hs_end: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      pix_tick && !hs_pend && hs_cnt == 8'h01 |=> !hs_act)
      else $error("regenerated hsync pulse width wrong");

   chk_hs_align: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $changed(regenerated_hsync_out_o) |-> $past(pix_tick) && !data_clock_out_o)
      else $error("hsync output moved off the data clock falling edge");

   chk_vs_level: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ##1 vertical_sync_out_o == ($past(vs_act) ^ $past(vs_invert_i)))
      else $error("vertical output level wrong");

   chk_vs_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !vs_dur_ovr_i |=> vs_act == $past(vs_src))
      else $error("vertical output did not follow source timing");

   chk_strap_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      strap_done |=> $stable(bus_address_select_lsb_o) && strap_done)
      else $error("address strap changed after capture");

   chk_vs_oe: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !strap_done |=> !vertical_sync_out_oe_o || strap_done)
      else $error("vertical output driven during strap window");

   chk_clk_runt: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(sw_clk) && !$past(ext_clk_active_o) && !ext_clk_active_o
      |=> sw_clk || $past(pll_half_period_i) <= 8'h01)
      else $error("runt pulse on data clock");

endmodule : scp_pin_ctrl

// >>> tb/scp_sync_source.sv
// Behavioural video source that makes horizontal sync pulses and an external pixel clock.
module scp_sync_source (
   input wire logic ref_clk_i,
   input wire logic run_i,
   output logic hsync_o = 1'b0,
   output logic ext_clk_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Position within one line, in reference cycles.
   int unsigned cnt = 0;
   // A line lasts 160 cycles with a 16 cycle active-high pulse. The clock divides by eight,
   // well under half the reference rate, and a line holds whole clock periods so the two
   // never drift. Outside a frame the clock stands still low.
   always @(posedge ref_clk_i) begin
      cnt <= run_i ? (cnt + 1) % 160 : 0;
      hsync_o <= run_i && cnt < 16;
      ext_clk_o <= run_i && cnt[2];
   end
endmodule : scp_sync_source

// >>> tb/testbench.sv
// Self-checking bench for the pin control block driven by the sync source model.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import scp_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, vs_pin = 1'b0, coast = 1'b0, pd_pin = 1'b0;
   logic strap_pull = 1'b1, ext_sel = 1'b0, coast_load = 1'b0, vs_inv = 1'b0, vs_mode = 1'b1;
   logic pd_man = 1'b0, pd_reg = 1'b0, pd_pol = 1'b1, hs_pol = 1'b1; // Power-down controls and hsync output polarity.
   logic [1:0] coast_set = 2'h1; // Coast pin starts low with polarity one.
   logic [7:0] hs_w = 8'h03, pll_hp = 8'h02, vs_w = 8'h02;
   logic cs_pin = 1'b0, vs_ovr = 1'b0; // Composite sync pin and vertical width override.
   logic [DATA_W-1:0] r = '0, g = '0, b = '0, r_o, g_o, b_o;
   logic hs, ext_ck, dck, hso, vso, vso_oe, lsb, pdn, ext_act, coast_act;
   // The shared pin shows the pull-up or pull-down whenever the block does not drive it.
   wire logic shared_pin = vso_oe ? vso : strap_pull;
   wire logic [7:0] mon = {pdn, ext_act, coast_act, vso, lsb, vso_oe, hso, dck};
   int mismatches = 0, tests_run = 0, run_len = 1000, min_run = 1000;
   int exp_q[$]; // Expected pixel words, red then green then blue.
   logic last_dck = 1'b0;

   initial forever #12.5 clk = ~clk;

   scp_sync_source scp_sync_source_i (.ref_clk_i(clk), .run_i(run), .hsync_o(hs),
      .ext_clk_o(ext_ck));

   scp_pin_ctrl scp_pin_ctrl_i (.ref_clk_i(clk), .rst_n_i(rst_n), .hsync_pin_i(hs),
      .vsync_pin_i(vs_pin), .csync_pin_i(cs_pin), .coast_pin_i(coast),
      .external_pixel_clock_in_i(ext_ck), .power_down_pin_i(pd_pin), .vs_addr_pin_i(shared_pin),
      .red_i(r), .green_i(g), .blue_i(b), .ext_clk_sel_i(ext_sel), .hs_pol_setting_i(2'h1),
      .vs_pol_setting_i(2'h1), .coast_pol_setting_i(coast_set), .coast_pol_load_i(coast_load),
      .pll_half_period_i(pll_hp), .hs_width_i(hs_w), .hs_out_pol_i(hs_pol),
      .vs_mode_i(vs_mode), .vs_invert_i(vs_inv), .vs_dur_ovr_i(vs_ovr), .vs_width_i(vs_w),
      .pd_manual_sel_i(pd_man), .pd_pin_pol_i(pd_pol), .pd_reg_i(pd_reg),
      .data_clock_out_o(dck), .red_o(r_o), .green_o(g_o), .blue_o(b_o),
      .regenerated_hsync_out_o(hso), .vertical_sync_out_o(vso),
      .vertical_sync_out_oe_o(vso_oe), .bus_address_select_lsb_o(lsb),
      .powered_down_o(pdn), .ext_clk_active_o(ext_act), .coast_active_o(coast_act));

   // Shortest high or low stretch of the data clock; the first stretch after reset or
   // power-down starts from a large count so it never counts as short.
   always @(posedge clk) begin
      if (!rst_n || pdn) begin
         run_len = 1000;
      end else if (dck !== last_dck) begin
         if (run_len < min_run) min_run = run_len;
         run_len = 1;
      end else begin
         run_len++;
      end
      last_dck = dck;
   end

   task automatic wrap_up();
      $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   // Waits a bounded time for one monitored output to reach a level, then compares it.
   task automatic wait_mon(input int idx, input logic exp, input int lim);
      int n;
      n = 0;
      while (mon[idx] !== exp && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_bit(mon[idx], exp);
      if (n >= lim) wrap_up();
   endtask : wait_mon

   // Counts data clock rises; falling short of the request within the limit means the clock stalled.
   task automatic count_rises(input int want, input int lim, output int got);
      logic p;
      int k;
      got = 0;
      k = 0;
      while (got < want && k < lim) begin
         p = dck;
         @(posedge clk);
         #1;
         if (dck && !p) got++;
         k++;
      end
      // A stalled clock is a failure in its own right and ends the run.
      if (got < want) begin
         mismatches++;
         wrap_up();
      end
   endtask : count_rises

   // Resets with the given strap level, checks the captured strap, and checks the output enable one edge later.
   task automatic rst_seq(input logic pull);
      @(posedge clk);
      rst_n <= 1'b0;
      strap_pull <= pull;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk_bit(lsb, pull);
      chk_bit(vso_oe, 1'b0);
      @(posedge clk);
      #1;
      chk_bit(vso_oe, 1'b1);
   endtask : rst_seq

   task automatic load_coast(input logic [1:0] s);
      @(posedge clk);
      coast_set <= s;
      coast_load <= 1'b1;
      @(posedge clk);
      coast_load <= 1'b0;
   endtask : load_coast

   initial begin
      int n;
      int w;
      int k;
      logic p;
      void'($urandom(32'hf8e6));
      rst_seq(1'b1);
      @(posedge clk);
      run <= 1'b1;
      @(posedge clk);
      coast <= 1'b1;
      wait_mon(5, 1'b1, 20);
      load_coast(2'h0);
      wait_mon(5, 1'b0, 20);
      @(posedge clk);
      coast <= 1'b0;
      wait_mon(5, 1'b1, 20);
      // Source switching both ways, with the clock high time and runts watched.
      min_run = 1000;
      for (int s = 1; s >= 0; s--) begin
         @(posedge clk);
         ext_sel <= s[0];
         wait_mon(6, s[0], 200);
         count_rises(2, 200, n);
         n = 0;
         while (dck === 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
         end
         chk_word(n[DATA_W-1:0], s ? 10'h004 : {2'h0, pll_hp});
         if (n >= 50) wrap_up();
         if (s == 1) begin
            @(posedge clk);
            coast <= 1'b1;
            wait_mon(5, 1'b0, 20);
         end
      end
      chk_bit(min_run >= int'(pll_hp), 1'b1);
      load_coast(2'h2);
      coast <= 1'b0;
      wait_mon(5, 1'b0, 600);
      load_coast(2'h1);
      wait_mon(5, 1'b0, 20);
      // Pixel words must appear with the data clock.
      repeat (4) begin
         @(posedge clk);
         for (int c = 0; c < 3; c++) exp_q.push_back($urandom % (1 << DATA_W));
         r <= exp_q[0][DATA_W-1:0];
         g <= exp_q[1][DATA_W-1:0];
         b <= exp_q[2][DATA_W-1:0];
         count_rises(3, 200, n);
         chk_word(r_o, exp_q.pop_front());
         chk_word(g_o, exp_q.pop_front());
         chk_word(b_o, exp_q.pop_front());
      end
      // Regenerated pulse width in data clocks for several widths and both polarities.
      // A pulse already under way when the settings change is skipped, so only a
      // pulse started with the new width is measured.
      for (int i = 0; i < 4; i++) begin
         w = (i == 0) ? 0 : 2 * i;
         @(posedge clk);
         hs_w <= w[7:0];
         hs_pol <= i[0];
         wait_mon(1, i[0], 400);
         wait_mon(1, !i[0], 400);
         wait_mon(1, i[0], 400);
         n = 0;
         k = 0;
         // Only rises seen while the pulse still stands are counted.
         while (hso === i[0] && k < 100) begin
            p = dck;
            @(posedge clk);
            #1;
            k++;
            if (dck && !p && hso === i[0]) n++;
         end
         chk_word(n[DATA_W-1:0], (w == 0) ? 10'h001 : w[DATA_W-1:0]);
         if (k >= 100) begin
            mismatches++;
            wrap_up();
         end
      end
      // Vertical output in pass-through mode, plain and inverted.
      for (int inv = 0; inv < 2; inv++) begin
         for (int lv = 0; lv < 2; lv++) begin
            @(posedge clk);
            vs_inv <= inv[0];
            vs_pin <= lv[0];
            wait_mon(4, lv[0] ^ inv[0], 20);
         end
      end
      // Composite sync must stay active past the broad pulse threshold to count as vertical.
      @(posedge clk);
      vs_inv <= 1'b0;
      vs_pin <= 1'b0;
      vs_mode <= 1'b0;
      cs_pin <= 1'b1;
      repeat (300) @(posedge clk);
      #1;
      chk_bit(vso, 1'b0);
      wait_mon(4, 1'b1, 200);
      @(posedge clk);
      cs_pin <= 1'b0;
      vs_mode <= 1'b1;
      wait_mon(4, 1'b0, 20);
      // Override: the pulse lasts two lines although the input stays active.
      @(posedge clk);
      vs_ovr <= 1'b1;
      vs_pin <= 1'b1;
      wait_mon(4, 1'b1, 20);
      repeat (100) @(posedge clk);
      #1;
      chk_bit(vso, 1'b1);
      wait_mon(4, 1'b0, 400);
      @(posedge clk);
      vs_pin <= 1'b0;
      vs_ovr <= 1'b0;
      chk_bit(lsb, strap_pull);
      // Power-down pin is ignored until manual control is chosen.
      @(posedge clk);
      pd_pin <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      chk_bit(pdn, 1'b0);
      @(posedge clk);
      pd_man <= 1'b1;
      wait_mon(7, 1'b1, 20);
      // The data clock is gated from the registered power-down, one edge later.
      @(posedge clk);
      #1;
      chk_bit(dck, 1'b0);
      @(posedge clk);
      pd_pin <= 1'b0;
      wait_mon(7, 1'b0, 20);
      rst_seq(1'b0);
      wrap_up();
   end
endmodule : testbench
